// ---- dv/test_watchdog_timer_with_sleep_modes.sv ----
// self-checking bench for the watchdog
`timescale 1ns/10ps
`include "wdts_defines.vh"
module test_watchdog_timer_with_sleep_modes;
  localparam TICK = 4;
  reg clock_i, reset_n_i, sleep_i, crystal_clock_i, ost_running_i, osc_fail_i, wr_i, rd_i;
  reg clear_watchdog_instruction_i = 1'b0;
  reg clr_run;
  reg [1:0] watchdog_mode_field_i;
  reg [3:0] internal_osc_divider_select_i = 4'h0;
  reg [2:0] addr_i;
  reg [7:0] wdata_i;
  wire [7:0] rdata_o;
  wire device_reset_o, wake_o, resume_next_o, irq_o;
  integer n_errors, check_count, m, s, e, p, act, nr, nw, nx;
  integer cycles = 0;
  wdts_top #(.TICK_CYC(TICK)) dut_u (.clock_i, .reset_n_i, .watchdog_mode_field_i, .sleep_i,
    .crystal_clock_i, .ost_running_i, .osc_fail_i, .clear_watchdog_instruction_i,
    .internal_osc_divider_select_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .device_reset_o,
    .wake_o, .resume_next_o, .irq_o);
  initial begin
    clock_i = 1'b0;
    forever #5 clock_i = ~clock_i;
  end
  // divider keeps moving; clear pulses alternate so each stays one cycle
  always @(posedge clock_i) begin
    cycles <= cycles + 1;
    internal_osc_divider_select_i <= internal_osc_divider_select_i + 4'h1;
    clear_watchdog_instruction_i <= clr_run & ~clear_watchdog_instruction_i;
    if (cycles == 20000) begin
      n_errors = n_errors + 1;
      conclude;
    end
  end
  // ------
  // helpers
  // ------
  task chk(input string nm, input logic [15:0] x, input logic [15:0] got);
    begin
      check_count = check_count + 1;
      if (got !== x) begin
        n_errors = n_errors + 1;
        $display("FAIL %s expected %h seen %h", nm, x, got);
      end
    end
  endtask
  task wr(input [2:0] a, input [7:0] d);
    begin
      addr_i <= a;
      wdata_i <= d;
      wr_i <= 1'b1;
      @(posedge clock_i);
      wr_i <= 1'b0;
    end
  endtask
  task rd(input [2:0] a, input [7:0] x);
    begin
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge clock_i);
      rd_i <= 1'b0;
      @(posedge clock_i);
      chk("rdata", x, rdata_o);
    end
  endtask
  task count(input integer k);
    begin
      nr = 0;
      nw = 0;
      nx = 0;
      repeat (k) begin
        @(posedge clock_i);
        nr = nr + device_reset_o;
        nw = nw + wake_o;
        nx = nx + resume_next_o;
      end
    end
  endtask
  task conclude;
    begin
      $display("checks %0d errors %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
    end
  endtask
  // ------
  // scenarios
  // ------
  task t_regs;
    begin
      rd(`WDTS_OFF_CTRL, 8'h16);
      rd(`WDTS_OFF_STAT, 8'h18);
      rd(3'h7, 8'h00);
      wr(`WDTS_OFF_CTRL, 8'hFF);
      rd(`WDTS_OFF_CTRL, 8'h3F);
    end
  endtask
  task t_modes;
    for (m = 0; m < 4; m = m + 1)
      for (s = 0; s < 2; s = s + 1)
        for (e = 0; e < 2; e = e + 1) begin
          // park the watchdog so pulses of the previous setting drain first
          watchdog_mode_field_i <= 2'h0;
          count(3);
          wr(`WDTS_OFF_CTRL, e[7:0]);
          watchdog_mode_field_i <= m[1:0];
          sleep_i <= s[0];
          count(40);
          act = m == 3 || (m == 2 && s == 0) || (m == 1 && e == 1);
          chk("resets", act && s == 0, nr != 0);
          chk("wakes", act && s == 1, nw != 0);
          chk("resumes", act && s == 1, nx != 0);
        end
  endtask
  task t_irq;
    begin
      watchdog_mode_field_i <= 2'h0;
      sleep_i <= 1'b0;
      wr(`WDTS_OFF_IRQ_MASK, 8'h01);
      wr(`WDTS_OFF_IRQ_STAT, 8'h03);
      rd(`WDTS_OFF_IRQ_STAT, 8'h00);
      watchdog_mode_field_i <= 2'h3;
      count(12);
      watchdog_mode_field_i <= 2'h0;
      rd(`WDTS_OFF_STAT, 8'h08);
      chk("irq", 1, irq_o);
      wr(`WDTS_OFF_IRQ_STAT, 8'h01);
      count(2);
      chk("irq", 0, irq_o);
      wr(`WDTS_OFF_IRQ_MASK, 8'h00);
      sleep_i <= 1'b1;
      watchdog_mode_field_i <= 2'h3;
      count(12);
      watchdog_mode_field_i <= 2'h0;
      rd(`WDTS_OFF_IRQ_STAT, 8'h02);
      rd(`WDTS_OFF_STAT, 8'h00);
      chk("irq", 0, irq_o);
    end
  endtask
  task t_hold;
    begin
      watchdog_mode_field_i <= 2'h3;
      crystal_clock_i <= 1'b1;
      ost_running_i <= 1'b1;
      count(40);
      sleep_i <= 1'b0;
      count(40);
      chk("held", 0, nr + nw);
      ost_running_i <= 1'b0;
      osc_fail_i <= 1'b1;
      count(40);
      chk("osc fail", 0, nr);
      // new period lands while the failure still holds the counter clear
      wr(`WDTS_OFF_CTRL, 8'h02);
      osc_fail_i <= 1'b0;
      clr_run <= 1'b1;
      count(40);
      chk("cleared", 0, nr);
      clr_run <= 1'b0;
      count(20);
      chk("released", 1, nr != 0);
    end
  endtask
  task t_period;
    for (p = 0; p < 4; p = p + 1) begin
      wr(`WDTS_OFF_CTRL, {2'h0, p[4:0], 1'h0});
      for (s = 0; s < 2; s = s + 1) begin
        e = 0;
        do begin
          @(posedge clock_i);
          e = e + 1;
        end while (device_reset_o !== 1'b1 && e < 200);
      end
      chk("period", TICK << p, e);
    end
  endtask
  initial begin
    {sleep_i, crystal_clock_i, ost_running_i, osc_fail_i, wr_i, rd_i, clr_run} = 7'h00;
    {addr_i, wdata_i, watchdog_mode_field_i} = 13'h0000;
    reset_n_i = 1'b0;
    {n_errors, check_count} = 64'h0;
    repeat (6) @(posedge clock_i);
    reset_n_i <= 1'b1;
    repeat (3) @(posedge clock_i);
    t_regs;
    t_modes;
    t_irq;
    t_hold;
    watchdog_mode_field_i <= 2'h3;
    t_period;
    conclude;
  end
endmodule // test_watchdog_timer_with_sleep_modes

// ---- dv/wdts_monitor.sv ----
// port checker for the watchdog top
`timescale 1ns/10ps
module wdts_monitor (
  // clock, reset and inputs
  input wire clock_i,
  input wire reset_n_i,
  input wire [1:0] watchdog_mode_field_i,
  input wire sleep_i,
  input wire ost_running_i,
  input wire osc_fail_i,
  input wire clear_watchdog_instruction_i,
  input wire rd_i,
  // outputs
  input wire [7:0] rdata_o,
  input wire device_reset_o,
  input wire wake_o,
  input wire resume_next_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!reset_n_i);
  sequence quiet_s;
    !device_reset_o && !wake_o;
  endsequence
  awake_reset_a: assert property (device_reset_o |-> !$past(sleep_i))
    else $error("reset pulse in sleep");
  sleep_wake_a: assert property (wake_o |-> $past(sleep_i) && $past(watchdog_mode_field_i) != 2'h2)
    else $error("bad wake pulse");
  resume_pair_a: assert property (wake_o == resume_next_o)
    else $error("resume differs from wake");
  mode_off_a: assert property ($past(watchdog_mode_field_i) == 2'h0 |-> quiet_s)
    else $error("pulse while off");
  osc_fail_a: assert property ($past(osc_fail_i) |-> quiet_s)
    else $error("pulse on osc fail");
  clear_instr_a: assert property ($past(clear_watchdog_instruction_i) |-> quiet_s)
    else $error("pulse on clear");
  ost_hold_a: assert property ($past(ost_running_i) |-> quiet_s)
    else $error("pulse during start-up");
  sleep_edge_a: assert property ($past(sleep_i) != $past(sleep_i, 2) |-> quiet_s)
    else $error("pulse at sleep change");
  pulse_once_a: assert property ((device_reset_o || wake_o) |=> quiet_s)
    else $error("pulse too long");
  read_stand_a: assert property (!$past(rd_i) |-> rdata_o == 8'h00)
    else $error("read data outside slot");
endmodule // wdts_monitor
bind wdts_top wdts_monitor mon_u (.clock_i, .reset_n_i, .watchdog_mode_field_i, .sleep_i,
  .ost_running_i, .osc_fail_i, .clear_watchdog_instruction_i, .rd_i, .rdata_o, .device_reset_o,
  .wake_o, .resume_next_o);

// ---- logic/wdts_top.v ----
// watchdog timer with sleep handling and a register port
//
// Implementation choices: strobed register access and the placing of the registers.
`timescale 1ns/10ps
// Notes on behaviour
// - counter steps on a 1 ms tick divided down from the system clock by TICK_CYC
// - mode 11: always active, also during sleep, soft enable ignored
// - mode 10: active while awake, disabled during sleep
// - mode 01: soft enable bit alone decides; sleep does not change it
// - mode 00, or 01 with enable low: disabled and held clear
// - prescale select sets time-out from 1 ms up to 256 s
// - after reset prescale select gives a 2 s time-out
// - clear on reset, clear instruction, oscillator fail, disabled, start-up timer running
// - clear on sleep entry, then keep counting if still enabled
// - clear on sleep exit; held clear until start-up timer done
// - crystal clocks hold clear until timer ends; others clear once
// - time-out in sleep wakes device, clears both status bits, no reset
// - internal oscillator divider change leaves counter untouched
// - wake from sleep resumes at next instruction, not reset vector
`include "wdts_defines.vh"
module wdts_top #(
  parameter TICK_CYC = `WDTS_TICK_CYC
) (
  // clock and reset
  input wire clock_i,
  input wire reset_n_i,
  // configuration and core status
  input wire [1:0] watchdog_mode_field_i,
  input wire sleep_i,
  input wire crystal_clock_i,
  input wire ost_running_i,
  input wire osc_fail_i,
  input wire clear_watchdog_instruction_i,
  input wire [3:0] internal_osc_divider_select_i,
  // register port
  input wire [2:0] addr_i,
  input wire [7:0] wdata_i,
  input wire wr_i,
  input wire rd_i,
  output reg [7:0] rdata_o,
  // outputs to the core
  output reg device_reset_o,
  output reg wake_o,
  output reg resume_next_o,
  output reg irq_o
);
  // ------------------------------------------------------------
  // reset release
  // ------------------------------------------------------------
  reg rst_s1_r;
  reg rst_s2_r;
  wire rst_n = rst_s2_r;
  always @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rst_s1_r <= 1'b0;
      rst_s2_r <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_s2_r <= rst_s1_r;
    end
  end
  // ------------------------------------------------------------
  // tick base
  // ------------------------------------------------------------
  // divider is free-running so the divider select never disturbs counting
  reg [23:0] tick_cnt_r;
  reg tick_r;
  always @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      tick_cnt_r <= 24'h000000;
      tick_r <= 1'b0;
    end else if (tick_cnt_r == TICK_CYC - 1) begin
      tick_cnt_r <= 24'h000000;
      tick_r <= 1'b1;
    end else begin
      tick_cnt_r <= tick_cnt_r + 24'h000001;
      tick_r <= 1'b0;
    end
  end
  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  reg soft_enable_bit_r;
  reg [4:0] timeout_prescale_select_r;
  reg timeout_status_bit_r;
  reg power_down_status_bit_r;
  reg [1:0] irq_stat_r;
  reg [1:0] irq_mask_r;
  reg [17:0] count_r;
  reg sleep_d_r;
  reg hold_r;
  // ------------------------------------------------------------
  // mode decode
  // ------------------------------------------------------------
  reg active;
  always @* begin
    case (watchdog_mode_field_i)
      `WDTS_MODE_ON: active = 1'b1;
      `WDTS_MODE_NOSLEEP: active = !sleep_i;
      `WDTS_MODE_SOFT: active = soft_enable_bit_r;
      default: active = 1'b0;
    endcase
  end
  wire sleep_enter = sleep_i && !sleep_d_r;
  wire sleep_exit = !sleep_i && sleep_d_r;
  // limit of 2^ps ticks, ps from 0 (1 ms) to 18 (256 s)
  wire [4:0] ps_eff = (timeout_prescale_select_r > 5'h12) ? 5'h12 : timeout_prescale_select_r;
  wire [18:0] limit = 19'h00001 << ps_eff;
  wire timeout = tick_r && ({1'b0, count_r} + 19'h00001 >= limit);
  wire clear = !active || clear_watchdog_instruction_i || osc_fail_i
    || ost_running_i || sleep_enter || sleep_exit || hold_r;
  wire to_sleep = timeout && sleep_i && !clear;
  wire to_awake = timeout && !sleep_i && !clear;
  // ------------------------------------------------------------
  // counter and sleep tracking
  // ------------------------------------------------------------
  // internal_osc_divider_select_i is deliberately unused
  always @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      count_r <= 18'h00000;
      sleep_d_r <= 1'b0;
      hold_r <= 1'b0;
    end else begin
      sleep_d_r <= sleep_i;
      if (sleep_exit && crystal_clock_i)
        hold_r <= 1'b1;
      else if (!ost_running_i)
        hold_r <= 1'b0;
      if (clear || timeout)
        count_r <= 18'h00000;
      else if (tick_r)
        count_r <= count_r + 18'h00001;
    end
  end
  // ------------------------------------------------------------
  // outputs to the core
  // ------------------------------------------------------------
  always @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      device_reset_o <= 1'b0;
      wake_o <= 1'b0;
      resume_next_o <= 1'b0;
    end else begin
      device_reset_o <= to_awake;
      wake_o <= to_sleep;
      resume_next_o <= to_sleep;
    end
  end
  // ------------------------------------------------------------
  // register writes and status
  // ------------------------------------------------------------
  wire wr_ctrl = wr_i && addr_i == `WDTS_OFF_CTRL;
  wire wr_stat = wr_i && addr_i == `WDTS_OFF_STAT;
  wire wr_iclr = wr_i && addr_i == `WDTS_OFF_IRQ_STAT;
  wire wr_imask = wr_i && addr_i == `WDTS_OFF_IRQ_MASK;
  wire [1:0] ev = {to_sleep, to_awake};
  wire [1:0] irq_stat_nxt;
  wire [1:0] irq_mask_nxt;
  // per-source sticky bit: the event wins over a same-cycle write-one clear
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi = gi + 1) begin : g_irq
      assign irq_stat_nxt[gi] = ev[gi] | (irq_stat_r[gi] & ~(wr_iclr & wdata_i[gi]));
      assign irq_mask_nxt[gi] = wr_imask ? wdata_i[gi] : irq_mask_r[gi];
    end
  endgenerate
  always @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      soft_enable_bit_r <= 1'b0;
      timeout_prescale_select_r <= `WDTS_PS_RESET;
      timeout_status_bit_r <= 1'b1;
      power_down_status_bit_r <= 1'b1;
      irq_stat_r <= 2'h0;
      irq_mask_r <= 2'h0;
      irq_o <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        soft_enable_bit_r <= wdata_i[`WDTS_CTRL_EN_BIT];
        timeout_prescale_select_r <= wdata_i[`WDTS_CTRL_PS_MSB:`WDTS_CTRL_PS_LSB];
      end
      // clear instruction sets both flags, bar PD on a same-cycle sleep entry; time-out writes TO low, PD low in sleep and high awake
      if (timeout && !clear)
        timeout_status_bit_r <= 1'b0;
      else if (clear_watchdog_instruction_i || (wr_stat && wdata_i[`WDTS_STAT_TO_BIT]))
        timeout_status_bit_r <= 1'b1;
      if (to_sleep)
        power_down_status_bit_r <= 1'b0;
      else if (sleep_enter)
        power_down_status_bit_r <= 1'b0;
      else if (clear_watchdog_instruction_i || (wr_stat && wdata_i[`WDTS_STAT_PD_BIT]))
        power_down_status_bit_r <= 1'b1;
      if (to_awake)
        power_down_status_bit_r <= 1'b1;
      irq_stat_r <= irq_stat_nxt;
      irq_mask_r <= irq_mask_nxt;
      irq_o <= |(irq_stat_nxt & irq_mask_nxt);
    end
  end
  // ------------------------------------------------------------
  // read port
  // ------------------------------------------------------------
  always @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      rdata_o <= 8'h00;
    end else if (rd_i) begin
      case (addr_i)
        `WDTS_OFF_CTRL: rdata_o <= {2'h0, timeout_prescale_select_r, soft_enable_bit_r};
        `WDTS_OFF_STAT: rdata_o <= {3'h0, timeout_status_bit_r, power_down_status_bit_r, 3'h0};
        `WDTS_OFF_IRQ_STAT: rdata_o <= {6'h00, irq_stat_r};
        `WDTS_OFF_IRQ_MASK: rdata_o <= {6'h00, irq_mask_r};
        `WDTS_OFF_CNT: rdata_o <= count_r[7:0];
        default: rdata_o <= 8'h00;
      endcase
    end else begin
      rdata_o <= 8'h00;
    end
  end
endmodule // wdts_top

// ---- shared/wdts_defines.vh ----
// register map, field layout, reset values and timing counts for the watchdog
`ifndef WDTS_DEFINES_VH
`define WDTS_DEFINES_VH
// ------------------------------------------------------------
// register offsets (word index on the plain port)
// ------------------------------------------------------------
`define WDTS_OFF_CTRL 3'h0
`define WDTS_OFF_STAT 3'h1
`define WDTS_OFF_IRQ_STAT 3'h2
`define WDTS_OFF_IRQ_MASK 3'h3
`define WDTS_OFF_CNT 3'h4
// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
`define WDTS_CTRL_EN_BIT 0
`define WDTS_CTRL_PS_LSB 1
`define WDTS_CTRL_PS_MSB 5
`define WDTS_STAT_PD_BIT 3
`define WDTS_STAT_TO_BIT 4
`define WDTS_IRQ_RST_BIT 0
`define WDTS_IRQ_WAKE_BIT 1
// ------------------------------------------------------------
// reset values and modes
// ------------------------------------------------------------
`define WDTS_PS_RESET 5'h0B
`define WDTS_MODE_OFF 2'h0
`define WDTS_MODE_SOFT 2'h1
`define WDTS_MODE_NOSLEEP 2'h2
`define WDTS_MODE_ON 2'h3
// ------------------------------------------------------------
// timing
// ------------------------------------------------------------
`define WDTS_CLK_MHZ 100
`define WDTS_TICK_US 1000
`define WDTS_TICK_CYC (`WDTS_TICK_US * `WDTS_CLK_MHZ)
`endif
